// ==== logic/bsc_branch_skip_call_unit.sv ====
// Purpose: Control-flow execution for the 8-bit core: calls, returns,
//          compares, skips and relative branches, with cycle timing.
// Assumes: Operation decoded upstream; operands valid with issue_valid_i.
// Notes:   One operation in flight; done_o marks its last cycle.
// What this block does
// - Indirect call loads PC from Z in 3; direct call from target in 4
// - Equal compare skip advances PC 2 or 3 on equality; flags kept
// - Compares subtract, drop result, update Z N V C H in one cycle
// - Register bit low skip jumps past next instruction when bit is 0
// - Register bit high skip jumps past next instruction when bit is 1
// - I/O bit low skip jumps past next instruction when I/O bit is 0
// - I/O bit high skip jumps past next instruction when I/O bit is 1
// - Branch on selected flag high: PC plus offset plus one, 1/2 cycles
// - Branch on selected flag low: PC plus offset plus one, 1/2 cycles
// - Equal branches on Z set, not equal on Z clear
// - Carry high and lower branch on C set; carry low, same-or-higher on C clear
// - Negative branches on N set, positive on N clear
// - Signed greater-or-equal branches when N xor V is 0
// - Signed less-than branches when N xor V is 1
// - Half carry branches on H set or H clear
// - Transfer flag branch taken when T is 1
// - Interrupt enabled branch on I set, disabled branch on I clear
// - Relative jump PC plus offset plus one in 2; relative call in 3
`timescale 1ns/1ps
`include "bsc_map.svh"

module bsc_branch_skip_call_unit
   import bsc_pkg::*;
(
   input logic mclk_i,
   input logic rst_n_i,
   input logic issue_valid_i,
   input bsc_op_t op_i,
   input logic [15:0] pc_i,
   input logic [15:0] imm_i,
   input logic [15:0] z_ptr_i,
   input logic [15:0] stack_pc_i,
   input logic [7:0] rd_val_i,
   input logic [7:0] rr_val_i,
   input logic [7:0] io_val_i,
   input logic [2:0] bit_sel_i,
   input logic next_two_word_i,
   input logic [7:0] flags_i,
   input logic psel_i,
   input logic penable_i,
   input logic pwrite_i,
   input logic [11:0] paddr_i,
   input logic [31:0] pwdata_i,
   output logic ready_o,
   output logic done_o,
   output logic [15:0] pc_o,
   output logic pc_load_o,
   output logic [7:0] flags_o,
   output logic flags_we_o,
   output logic push_o,
   output logic [15:0] push_data_o,
   output logic pop_o,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);

   bsc_state_t q;
   bsc_state_t n;
   logic acc_w;

   // Operation accepted this cycle
   assign acc_w = q.ready & issue_valid_i & q.enable;

   // Next-state logic for sequencer and register slave
   always_comb begin
      logic [15:0] tgt;
      logic [15:0] nxt;
      logic [2:0] ncyc;
      logic [8:0] diff;
      logic [7:0] b;
      logic [7:0] r;
      logic cin;
      logic take;
      logic br;
      logic sk;
      logic cmp;
      tgt = pc_i + imm_i + 16'h0001;
      nxt = pc_i + 16'h0001;
      ncyc = `BSC_CYC_ONE;
      b = rr_val_i;
      cin = 1'b0;
      diff = 9'h000;
      r = 8'h00;
      take = 1'b0;
      br = 1'b0;
      sk = 1'b0;
      cmp = 1'b0;
      n = q;
      n.done = 1'b0;
      n.pc_load = 1'b0;
      n.flags_we = 1'b0;
      n.push = 1'b0;
      n.pop = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;

      if (acc_w) begin
         n.pc = nxt;
         n.flags = flags_i;
         n.p_fwe = 1'b0;
         n.p_push = 1'b0;
         n.p_pop = 1'b0;
         n.taken = 1'b0;
         case (op_i)
            OP_INDIRECT_SUBROUTINE_JUMP: begin
               n.pc = z_ptr_i;
               n.p_push = 1'b1;
               n.push_data = nxt;
               ncyc = `BSC_CYC_IND_CALL;
            end
            OP_DIRECT_SUBROUTINE_JUMP: begin
               n.pc = imm_i;
               n.p_push = 1'b1;
               n.push_data = pc_i + 16'h0002;
               ncyc = `BSC_CYC_CALL;
            end
            OP_SUBROUTINE_EXIT: begin
               n.pc = stack_pc_i;
               n.p_pop = 1'b1;
               ncyc = `BSC_CYC_RETURN;
            end
            OP_INTERRUPT_HANDLER_EXIT: begin
               n.pc = stack_pc_i;
               n.p_pop = 1'b1;
               n.p_fwe = 1'b1;
               n.flags[`BSC_FLAG_I] = 1'b1;
               ncyc = `BSC_CYC_RETURN;
            end
            OP_EQUAL_COMPARE_SKIP: begin
               sk = 1'b1;
               take = (rd_val_i == rr_val_i);
            end
            OP_COMPARE_REGS: cmp = 1'b1;
            OP_COMPARE_WITH_BORROW: begin
               cmp = 1'b1;
               cin = flags_i[`BSC_FLAG_C];
            end
            OP_COMPARE_IMMEDIATE: begin
               cmp = 1'b1;
               b = imm_i[7:0];
            end
            OP_SKIP_ON_REG_BIT_LOW: begin
               sk = 1'b1;
               take = ~rd_val_i[bit_sel_i];
            end
            OP_SKIP_ON_REG_BIT_HIGH: begin
               sk = 1'b1;
               take = rd_val_i[bit_sel_i];
            end
            OP_SKIP_ON_IO_BIT_LOW: begin
               sk = 1'b1;
               take = ~io_val_i[bit_sel_i];
            end
            OP_SKIP_ON_IO_BIT_HIGH: begin
               sk = 1'b1;
               take = io_val_i[bit_sel_i];
            end
            OP_BRANCH_FLAG_HIGH: begin
               br = 1'b1;
               take = flags_i[bit_sel_i];
            end
            OP_BRANCH_FLAG_LOW: begin
               br = 1'b1;
               take = ~flags_i[bit_sel_i];
            end
            OP_BRANCH_EQUAL: begin
               br = 1'b1;
               take = flags_i[`BSC_FLAG_Z];
            end
            OP_BRANCH_NOT_EQUAL: begin
               br = 1'b1;
               take = ~flags_i[`BSC_FLAG_Z];
            end
            OP_BRANCH_CARRY_HIGH, OP_BRANCH_LOWER: begin
               br = 1'b1;
               take = flags_i[`BSC_FLAG_C];
            end
            OP_BRANCH_CARRY_LOW, OP_BRANCH_SAME_OR_HIGHER: begin
               br = 1'b1;
               take = ~flags_i[`BSC_FLAG_C];
            end
            OP_BRANCH_NEGATIVE: begin
               br = 1'b1;
               take = flags_i[`BSC_FLAG_N];
            end
            OP_BRANCH_POSITIVE: begin
               br = 1'b1;
               take = ~flags_i[`BSC_FLAG_N];
            end
            OP_BRANCH_SIGNED_GE: begin
               br = 1'b1;
               take = ~(flags_i[`BSC_FLAG_N] ^ flags_i[`BSC_FLAG_V]);
            end
            OP_BRANCH_SIGNED_LT: begin
               br = 1'b1;
               take = flags_i[`BSC_FLAG_N] ^ flags_i[`BSC_FLAG_V];
            end
            OP_BRANCH_HALF_CARRY_HIGH: begin
               br = 1'b1;
               take = flags_i[`BSC_FLAG_H];
            end
            OP_BRANCH_HALF_CARRY_LOW: begin
               br = 1'b1;
               take = ~flags_i[`BSC_FLAG_H];
            end
            OP_BRANCH_TRANSFER_FLAG_HIGH: begin
               br = 1'b1;
               take = flags_i[`BSC_FLAG_T];
            end
            OP_BRANCH_IRQ_ENABLED: begin
               br = 1'b1;
               take = flags_i[`BSC_FLAG_I];
            end
            OP_BRANCH_IRQ_DISABLED: begin
               br = 1'b1;
               take = ~flags_i[`BSC_FLAG_I];
            end
            OP_RELATIVE_JUMP: begin
               n.pc = tgt;
               ncyc = `BSC_CYC_REL_JUMP;
            end
            OP_RELATIVE_SUBROUTINE_JUMP: begin
               n.pc = tgt;
               n.p_push = 1'b1;
               n.push_data = nxt;
               ncyc = `BSC_CYC_REL_CALL;
            end
            default: ncyc = `BSC_CYC_ONE;
         endcase

         if (cmp) begin
            diff = {1'b0, rd_val_i} - {1'b0, b} - {8'h00, cin};
            r = diff[7:0];
            n.p_fwe = 1'b1;
            n.flags[`BSC_FLAG_C] = (~rd_val_i[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~rd_val_i[7]);
            n.flags[`BSC_FLAG_H] = (~rd_val_i[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~rd_val_i[3]);
            n.flags[`BSC_FLAG_V] = (rd_val_i[7] & ~b[7] & ~r[7]) | (~rd_val_i[7] & b[7] & r[7]);
            n.flags[`BSC_FLAG_N] = r[7];
            n.flags[`BSC_FLAG_Z] = (r == 8'h00) & ((op_i != OP_COMPARE_WITH_BORROW) | flags_i[`BSC_FLAG_Z]);
         end

         // Taken branch target and timing
         if (br) begin
            n.taken = take;
            if (take) begin
               n.pc = tgt;
               ncyc = `BSC_CYC_BR_TAKEN;
            end
         end

         if (sk) begin
            n.taken = take;
            if (take) begin
               n.pc = next_two_word_i ? pc_i + 16'h0003 : pc_i + 16'h0002;
               ncyc = next_two_word_i ? `BSC_CYC_SKIP_LONG : `BSC_CYC_SKIP_SHORT;
            end
         end

         // Finish now or hold for more cycles
         if (ncyc == `BSC_CYC_ONE) begin
            n.done = 1'b1;
            n.pc_load = 1'b1;
            n.flags_we = n.p_fwe;
            n.push = n.p_push;
            n.pop = n.p_pop;
            n.icount = q.icount + 16'h0001;
         end else begin
            n.st = ST_BUSY;
            n.ready = 1'b0;
            n.cnt = ncyc - 3'h1;
         end
      end

      // Count down the remaining cycles
      case (q.st)
         ST_IDLE: n.cnt = n.cnt;
         ST_BUSY: begin
            n.cnt = q.cnt - 3'h1;
            if (q.cnt == 3'h1) begin
               n.st = ST_IDLE;
               n.ready = 1'b1;
               n.done = 1'b1;
               n.pc_load = 1'b1;
               n.flags_we = q.p_fwe;
               n.push = q.p_push;
               n.pop = q.p_pop;
               n.icount = q.icount + 16'h0001;
            end
         end
         default: n.st = ST_IDLE;
      endcase

      // APB setup phase: decode and answer next cycle
      if (psel_i && !penable_i) begin
         n.pready = 1'b1;
         case (paddr_i)
            `BSC_CTRL_OFF: n.prdata = {31'h00000000, q.enable};
            `BSC_STAT_OFF: n.prdata = {15'h0000, q.taken, q.pc};
            `BSC_ICNT_OFF: n.prdata = {16'h0000, q.icount};
            default: begin
               n.prdata = 32'h00000000;
               n.pslverr = 1'b1;
            end
         endcase
      end

      // APB write takes effect at the end of access
      if (psel_i && penable_i && q.pready && pwrite_i && (paddr_i == `BSC_CTRL_OFF)) begin
         n.enable = pwdata_i[`BSC_CTRL_EN_BIT];
      end
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.ready <= 1'b1;
         q.enable <= `BSC_CTRL_RST;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from the state register
   assign ready_o = q.ready;
   assign done_o = q.done;
   assign pc_o = q.pc;
   assign pc_load_o = q.pc_load;
   assign flags_o = q.flags;
   assign flags_we_o = q.flags_we;
   assign push_o = q.push;
   assign push_data_o = q.push_data;
   assign pop_o = q.pop;
   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;

   // Checks on timing and program counter
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_fin;
      done_o && pc_load_o;
   endsequence
   sequence s_taken;
      pc_o == $past(pc_i) + $past(imm_i) + 16'h0001 ##1 s_fin;
   endsequence
   sequence s_not;
      s_fin and (pc_o == $past(pc_i) + 16'h0001);
   endsequence

   property p_ind_call;
      acc_w && op_i == OP_INDIRECT_SUBROUTINE_JUMP
         |=> pc_o == $past(z_ptr_i) && !done_o ##2 (s_fin and push_o);
   endproperty
   a_ind_call: assert property (p_ind_call) else $error("indirect call timing");
   property p_call;
      acc_w && op_i == OP_DIRECT_SUBROUTINE_JUMP |=> pc_o == $past(imm_i) ##3 s_fin;
   endproperty
   a_call: assert property (p_call) else $error("direct call timing");
   property p_eq_skip;
      acc_w && op_i == OP_EQUAL_COMPARE_SKIP && rd_val_i == rr_val_i && !next_two_word_i
         |=> pc_o == $past(pc_i) + 16'h0002 && !done_o ##1 (s_fin and !flags_we_o);
   endproperty
   a_eq_skip: assert property (p_eq_skip) else $error("equal skip wrong");
   property p_cmp;
      acc_w && op_i == OP_COMPARE_REGS
         |=> done_o && flags_we_o && flags_o[`BSC_FLAG_Z] == ($past(rd_val_i) == $past(rr_val_i));
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare flags wrong");
   property p_reg_low_skip;
      acc_w && op_i == OP_SKIP_ON_REG_BIT_LOW && !rd_val_i[bit_sel_i] && next_two_word_i
         |=> pc_o == $past(pc_i) + 16'h0003 ##2 s_fin;
   endproperty
   a_reg_low_skip: assert property (p_reg_low_skip) else $error("reg bit low skip wrong");
   property p_reg_high_skip;
      acc_w && op_i == OP_SKIP_ON_REG_BIT_HIGH && !rd_val_i[bit_sel_i] |=> s_not;
   endproperty
   a_reg_high_skip: assert property (p_reg_high_skip) else $error("reg bit high skip wrong");
   property p_io_low_skip;
      acc_w && op_i == OP_SKIP_ON_IO_BIT_LOW && !io_val_i[bit_sel_i] && !next_two_word_i
         |=> pc_o == $past(pc_i) + 16'h0002 ##1 s_fin;
   endproperty
   a_io_low_skip: assert property (p_io_low_skip) else $error("io bit low skip wrong");
   property p_io_high_skip;
      acc_w && op_i == OP_SKIP_ON_IO_BIT_HIGH && !io_val_i[bit_sel_i] |=> s_not;
   endproperty
   a_io_high_skip: assert property (p_io_high_skip) else $error("io bit high skip wrong");
   property p_flag_high_br;
      acc_w && op_i == OP_BRANCH_FLAG_HIGH && flags_i[bit_sel_i] |=> s_taken;
   endproperty
   a_flag_high_br: assert property (p_flag_high_br) else $error("flag high branch wrong");
   property p_flag_low_br;
      acc_w && op_i == OP_BRANCH_FLAG_LOW && flags_i[bit_sel_i] |=> s_not;
   endproperty
   a_flag_low_br: assert property (p_flag_low_br) else $error("flag low branch wrong");
   property p_eq_br;
      acc_w && op_i == OP_BRANCH_EQUAL && flags_i[`BSC_FLAG_Z] |=> s_taken;
   endproperty
   a_eq_br: assert property (p_eq_br) else $error("equal branch wrong");
   property p_lower_br;
      acc_w && op_i == OP_BRANCH_LOWER && flags_i[`BSC_FLAG_C] |=> s_taken;
   endproperty
   a_lower_br: assert property (p_lower_br) else $error("lower branch wrong");
   property p_pos_br;
      acc_w && op_i == OP_BRANCH_POSITIVE && flags_i[`BSC_FLAG_N] |=> s_not;
   endproperty
   a_pos_br: assert property (p_pos_br) else $error("positive branch wrong");
   property p_sge_br;
      acc_w && op_i == OP_BRANCH_SIGNED_GE && (flags_i[`BSC_FLAG_N] == flags_i[`BSC_FLAG_V]) |=> s_taken;
   endproperty
   a_sge_br: assert property (p_sge_br) else $error("signed ge branch wrong");
   property p_slt_br;
      acc_w && op_i == OP_BRANCH_SIGNED_LT && (flags_i[`BSC_FLAG_N] == flags_i[`BSC_FLAG_V]) |=> s_not;
   endproperty
   a_slt_br: assert property (p_slt_br) else $error("signed lt branch wrong");
   property p_hc_low_br;
      acc_w && op_i == OP_BRANCH_HALF_CARRY_LOW && !flags_i[`BSC_FLAG_H] |=> s_taken;
   endproperty
   a_hc_low_br: assert property (p_hc_low_br) else $error("half carry branch wrong");
   property p_tflag_br;
      acc_w && op_i == OP_BRANCH_TRANSFER_FLAG_HIGH && flags_i[`BSC_FLAG_T] |=> s_taken;
   endproperty
   a_tflag_br: assert property (p_tflag_br) else $error("transfer flag branch wrong");
   property p_irq_exit;
      acc_w && op_i == OP_INTERRUPT_HANDLER_EXIT |=> pc_o == $past(stack_pc_i) && flags_o[`BSC_FLAG_I]
         ##3 (s_fin and (pop_o && flags_we_o));
   endproperty
   a_irq_exit: assert property (p_irq_exit) else $error("interrupt return wrong");
   property p_irq_off_br;
      acc_w && op_i == OP_BRANCH_IRQ_DISABLED && !flags_i[`BSC_FLAG_I] |=> s_taken;
   endproperty
   a_irq_off_br: assert property (p_irq_off_br) else $error("irq disabled branch wrong");
   property p_rel_call;
      acc_w && op_i == OP_RELATIVE_SUBROUTINE_JUMP |=> !done_o [*2] ##1 (s_fin and push_o);
   endproperty
   a_rel_call: assert property (p_rel_call) else $error("relative call timing");

endmodule

// ==== logic/bsc_map.svh ====
// Purpose: Offsets, field positions, reset values and cycle counts of the
//          branch, skip and call unit.
// Assumes: Included by bare name from the unit.
// Notes:   Definitions only.
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

// Register offsets on the APB slave
`define BSC_CTRL_OFF 12'h000
`define BSC_STAT_OFF 12'h004
`define BSC_ICNT_OFF 12'h008

// Control register layout and reset value
`define BSC_CTRL_EN_BIT 0
`define BSC_CTRL_RST 1'b1

// Status register layout
`define BSC_STAT_TAKEN_BIT 16

// Flag register bit positions
`define BSC_FLAG_C 0
`define BSC_FLAG_Z 1
`define BSC_FLAG_N 2
`define BSC_FLAG_V 3
`define BSC_FLAG_S 4
`define BSC_FLAG_H 5
`define BSC_FLAG_T 6
`define BSC_FLAG_I 7

// Cycle counts per operation
`define BSC_CYC_ONE 3'h1
`define BSC_CYC_BR_TAKEN 3'h2
`define BSC_CYC_SKIP_SHORT 3'h2
`define BSC_CYC_SKIP_LONG 3'h3
`define BSC_CYC_IND_CALL 3'h3
`define BSC_CYC_CALL 3'h4
`define BSC_CYC_RETURN 3'h4
`define BSC_CYC_REL_JUMP 3'h2
`define BSC_CYC_REL_CALL 3'h3

`endif

// ==== logic/bsc_pkg.sv ====
// Purpose: Types shared by the branch, skip and call unit.
// Assumes: Constants live in bsc_map.svh.
// Notes:   The unit's whole state is one packed struct.
package bsc_pkg;

   // Decoded control-flow operations
   typedef enum logic [4:0] {
      OP_OTHER,
      OP_INDIRECT_SUBROUTINE_JUMP, OP_DIRECT_SUBROUTINE_JUMP,
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_HANDLER_EXIT,
      OP_EQUAL_COMPARE_SKIP, OP_COMPARE_REGS, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE,
      OP_SKIP_ON_REG_BIT_LOW, OP_SKIP_ON_REG_BIT_HIGH, OP_SKIP_ON_IO_BIT_LOW, OP_SKIP_ON_IO_BIT_HIGH,
      OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
      OP_BRANCH_CARRY_HIGH, OP_BRANCH_CARRY_LOW, OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER,
      OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALF_CARRY_HIGH, OP_BRANCH_HALF_CARRY_LOW, OP_BRANCH_TRANSFER_FLAG_HIGH,
      OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
      OP_RELATIVE_JUMP, OP_RELATIVE_SUBROUTINE_JUMP
   } bsc_op_t;

   // Sequencer states
   typedef enum logic {
      ST_IDLE,
      ST_BUSY
   } bsc_st_t;

   // Whole register state of the unit
   typedef struct packed {
      bsc_st_t st;
      logic [2:0] cnt;
      logic ready;
      logic done;
      logic [15:0] pc;
      logic pc_load;
      logic [7:0] flags;
      logic flags_we;
      logic push;
      logic [15:0] push_data;
      logic pop;
      logic p_fwe;
      logic p_push;
      logic p_pop;
      logic taken;
      logic enable;
      logic [15:0] icount;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } bsc_state_t;

endpackage

// ==== dv/bsc_branch_skip_call_unit_tb.sv ====
// Purpose: Self-checking bench for the branch, skip and call unit.
// Assumes: Operations issued one at a time; APB master with waits on pready.
// Notes:   Model computes target, cycle count, strobes and flags.
`timescale 1ns/1ps
module bsc_branch_skip_call_unit_tb import bsc_pkg::*; ;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, issue_valid_i = 1'b0, next_two_word_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   bsc_op_t op_i = OP_OTHER;
   logic [15:0] pc_i = 16'h0, imm_i = 16'h0, z_ptr_i = 16'h0, stack_pc_i = 16'h0;
   logic [7:0] rd_val_i = 8'h0, rr_val_i = 8'h0, io_val_i = 8'h0, flags_i = 8'h0;
   logic [2:0] bit_sel_i = 3'h0;
   logic [11:0] paddr_i = 12'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, r;
   logic ready_o, done_o, pc_load_o, flags_we_o, push_o, pop_o, pready_o, pslverr_o, e, last_tk;
   logic [15:0] pc_o, push_data_o;
   logic [7:0] flags_o;
   int fails = 0, n_checks = 0, seed = 95970, cyc = 0, last_pc, cnt0;

   // Unit under test
   bsc_branch_skip_call_unit bsc_branch_skip_call_unit_i (.mclk_i, .rst_n_i, .issue_valid_i, .op_i, .pc_i,
      .imm_i, .z_ptr_i, .stack_pc_i, .rd_val_i, .rr_val_i, .io_val_i, .bit_sel_i, .next_two_word_i,
      .flags_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .ready_o, .done_o, .pc_o,
      .pc_load_o, .flags_o, .flags_we_o, .push_o, .push_data_o, .pop_o, .prdata_o, .pready_o, .pslverr_o);

   // Clock and hang guard
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("Checks made %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // APB transfer, held until pready seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      // Only pready high or the bench timeout ends this wait
      do begin
         @(posedge mclk_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
   endtask

   // Compare flags: Z N V C H from a - b - ci, S and the rest kept
   function automatic logic [7:0] cmpf(input logic [7:0] a, b, input logic ci, kz, input logic [7:0] f);
      logic [7:0] x;
      x = a - b - ci;
      cmpf = f;
      cmpf[0] = (~a[7] & b[7]) | (b[7] & x[7]) | (x[7] & ~a[7]);
      cmpf[5] = (~a[3] & b[3]) | (b[3] & x[3]) | (x[3] & ~a[3]);
      cmpf[3] = (a[7] & ~b[7] & ~x[7]) | (~a[7] & b[7] & x[7]);
      cmpf[2] = x[7];
      cmpf[1] = kz ? (x == 8'h00) & f[1] : (x == 8'h00);
   endfunction

   // One operation with random operands, model against design
   task automatic run(input bsc_op_t op);
      int ep, en, epd, n;
      logic fw, pu, po, sk, br;
      logic [7:0] a, ef, f;
      logic [2:0] b;
      @(posedge mclk_i);
      a = $random(seed);
      op_i <= op; issue_valid_i <= 1'b1; rd_val_i <= a;
      rr_val_i <= $random(seed) & 1 ? a : $random(seed);
      pc_i <= $random(seed); imm_i <= $random(seed); z_ptr_i <= $random(seed);
      stack_pc_i <= $random(seed); io_val_i <= $random(seed); bit_sel_i <= $random(seed);
      next_two_word_i <= $random(seed); flags_i <= $random(seed);
      #1;
      f = flags_i; b = bit_sel_i; ef = f;
      ep = pc_i + 1; en = 1; epd = pc_i + 1;
      {fw, pu, po, sk, br} = 5'h00;
      case (op_i)
         OP_INDIRECT_SUBROUTINE_JUMP: begin ep = z_ptr_i; en = 3; pu = 1; end
         OP_DIRECT_SUBROUTINE_JUMP: begin ep = imm_i; en = 4; pu = 1; epd = pc_i + 2; end
         OP_SUBROUTINE_EXIT: begin ep = stack_pc_i; en = 4; po = 1; end
         OP_INTERRUPT_HANDLER_EXIT: begin ep = stack_pc_i; en = 4; po = 1; fw = 1; ef[7] = 1'b1; end
         OP_COMPARE_REGS: begin fw = 1; ef = cmpf(rd_val_i, rr_val_i, 1'b0, 1'b0, f); end
         OP_COMPARE_WITH_BORROW: begin fw = 1; ef = cmpf(rd_val_i, rr_val_i, f[0], 1'b1, f); end
         OP_COMPARE_IMMEDIATE: begin fw = 1; ef = cmpf(rd_val_i, imm_i[7:0], 1'b0, 1'b0, f); end
         OP_EQUAL_COMPARE_SKIP: sk = rd_val_i == rr_val_i;
         OP_SKIP_ON_REG_BIT_LOW: sk = !rd_val_i[b];
         OP_SKIP_ON_REG_BIT_HIGH: sk = rd_val_i[b];
         OP_SKIP_ON_IO_BIT_LOW: sk = !io_val_i[b];
         OP_SKIP_ON_IO_BIT_HIGH: sk = io_val_i[b];
         OP_BRANCH_FLAG_HIGH: br = f[b];
         OP_BRANCH_FLAG_LOW: br = !f[b];
         OP_BRANCH_EQUAL: br = f[1];
         OP_BRANCH_NOT_EQUAL: br = !f[1];
         OP_BRANCH_CARRY_HIGH, OP_BRANCH_LOWER: br = f[0];
         OP_BRANCH_CARRY_LOW, OP_BRANCH_SAME_OR_HIGHER: br = !f[0];
         OP_BRANCH_NEGATIVE: br = f[2];
         OP_BRANCH_POSITIVE: br = !f[2];
         OP_BRANCH_SIGNED_GE: br = !(f[2] ^ f[3]);
         OP_BRANCH_SIGNED_LT: br = f[2] ^ f[3];
         OP_BRANCH_HALF_CARRY_HIGH: br = f[5];
         OP_BRANCH_HALF_CARRY_LOW: br = !f[5];
         OP_BRANCH_TRANSFER_FLAG_HIGH: br = f[6];
         OP_BRANCH_IRQ_ENABLED: br = f[7];
         OP_BRANCH_IRQ_DISABLED: br = !f[7];
         OP_RELATIVE_JUMP: begin ep = pc_i + imm_i + 1; en = 2; end
         OP_RELATIVE_SUBROUTINE_JUMP: begin ep = pc_i + imm_i + 1; en = 3; pu = 1; end
         default: ;
      endcase
      // skip length by next word count
      if (sk) begin
         ep = pc_i + (next_two_word_i ? 3 : 2);
         en = next_two_word_i ? 3 : 2;
      end
      if (br) begin
         ep = pc_i + imm_i + 1;
         en = 2;
      end
      @(posedge mclk_i);
      issue_valid_i <= 1'b0;
      n = 1;
      #1;
      while (done_o !== 1'b1 && n < 8) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      last_pc = ep;
      last_tk = sk | br;
      chk(n, en, "cycles");
      chk(pc_o, ep[15:0], "pc");
      chk(pc_load_o, 1'b1, "pc load");
      chk(flags_we_o, fw, "flag write");
      if (fw) chk(flags_o, ef, "flags");
      chk(push_o, pu, "push");
      if (pu) chk(push_data_o, epd[15:0], "return address");
      chk(pop_o, po, "pop");
   endtask

   initial begin
      int k, o;
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1;
      chk(ready_o, 1'b1, "ready after reset");
      chk(pc_o, 16'h0000, "pc after reset");
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 32'h1, "ctrl reset");
      apb(1'b0, 12'h008, 32'h0);
      cnt0 = r;
      for (k = 0; k < 6; k++) begin
         for (o = 0; o <= 31; o++) run(bsc_op_t'(o));
      end
      apb(1'b0, 12'h008, 32'h0);
      chk(r, (cnt0 + 192) & 32'hFFFF, "op count");
      apb(1'b0, 12'h004, 32'h0);
      chk(r[15:0], last_pc[15:0], "status pc");
      chk(r[16], last_tk, "status taken after call");
      apb(1'b0, 12'h00C, 32'h0);
      chk(e, 1'b1, "unmapped error");
      chk(r, 32'h0, "unmapped data");
      // Disabled unit ignores offered operations
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 32'h0, "ctrl readback");
      @(posedge mclk_i);
      op_i <= OP_COMPARE_REGS;
      issue_valid_i <= 1'b1;
      for (k = 0; k < 6; k++) begin
         @(posedge mclk_i);
         #1;
         chk(done_o, 1'b0, "done while disabled");
      end
      @(posedge mclk_i);
      issue_valid_i <= 1'b0;
      apb(1'b1, 12'h000, 32'h1);
      run(OP_BRANCH_EQUAL);
      apb(1'b0, 12'h004, 32'h0);
      chk(r[16], last_tk, "status taken after branch");
      chk(r[15:0], last_pc[15:0], "status pc after branch");
      give_verdict();
   end
endmodule
